//--- design/misc_strap_pkg.sv
// Purpose: Shared constants for the strap and miscellaneous control block
// Assumes: 40 MHz system clock, APB register access
// Notes: Register offsets are word indices; the byte address is four times the index
package misc_strap_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REF_LOSS_NS = 400;
   localparam int REF_LOSS_CYC = REF_LOSS_NS / CLK_PERIOD_NS;
   localparam int INT_HALF_CYC = 2;

   localparam logic [7:0] ANEG_CTRL_IDX = 8'h00;
   localparam logic [7:0] CFG29_IDX = 8'h1d;
   localparam logic [7:0] CFG30_IDX = 8'h1e;
   localparam logic [7:0] STAT_IDX = 8'h1f;

   localparam int ANEG_EN_BIT = 12;
   localparam int CIM_BIT = 3;
   localparam int SCR_BIT = 4;
   localparam int CODEC_BIT = 6;
   localparam int REFSEL_BIT = 2;

   localparam logic [31:0] ANEG_CTRL_MASK = 32'h0000_1000;
   localparam logic [31:0] CFG29_MASK = 32'h0000_0058;
   localparam logic [31:0] CFG30_MASK = 32'h0000_0004;
   localparam logic [31:0] ANEG_CTRL_RST = 32'h0000_1000;
   localparam logic [31:0] CFG29_RST = 32'h0000_0000;
   localparam logic [31:0] CFG30_RST = 32'h0000_0000;

   // Strap pad positions, port A upward
   localparam int REF_SELECT_STRAP = 0;
   localparam int SCRAMBLER_BYPASS_STRAP = 1;
   localparam int CODEC_BYPASS_STRAP = 2;
   localparam int CARRIER_INTEGRITY_STRAP = 3;

   typedef struct packed {
      logic aneg;
      logic refsel;
      logic codec;
      logic scr;
      logic cim;
   } cfg_t;
endpackage : misc_strap_pkg

//--- design/ref_ctrl_if.sv
// Purpose: Carries reference selection and clock status between the blocks
// Assumes: Both ends on clk_i
// Notes: None
`timescale 1ns/1ps
interface ref_ctrl_if;
   logic ref_sel;
   logic ext_active;
   logic rep_active;
   logic use_rep;
   logic tx_clk;
   modport main (output ref_sel, input ext_active, input rep_active, input use_rep,
                 input tx_clk);
   modport leaf (input ref_sel, output ext_active, output rep_active, output use_rep,
                 output tx_clk);
endinterface : ref_ctrl_if

//--- design/ref_clk_select.sv
// Purpose: Watches both reference clock pins and builds the transmit clock
// Assumes: References sampled by clk_i; the repeater reference is well below clk_i/2
// Notes: The 20 MHz pin sits at clk_i/2, so activity detection there is best effort
`timescale 1ns/1ps
module ref_clk_select
   import misc_strap_pkg::*;
#(
   parameter int LOSS_CYCLES = REF_LOSS_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Reference pins
   input wire logic repeater_ref_clk_in_i,
   input wire logic ext_ref_clk_in_i,
   // Towards the main block
   ref_ctrl_if.leaf rif
);
   localparam logic [7:0] LOSS8 = 8'(LOSS_CYCLES);
   localparam logic [1:0] DIV_LAST = 2'(INT_HALF_CYC - 1);

   typedef struct packed {
      logic rep_m;
      logic rep_s;
      logic rep_p;
      logic ext_m;
      logic ext_s;
      logic ext_p;
      logic [7:0] rep_cnt;
      logic [7:0] ext_cnt;
      logic [1:0] div;
      logic tx_clk;
      logic use_rep;
   } leaf_t;

   leaf_t s_q;
   leaf_t s_d;

   initial begin
      if (LOSS_CYCLES < 1 || LOSS_CYCLES > 255) $error("LOSS_CYCLES out of range");
   end

   always_comb begin
      s_d = s_q;
      s_d.rep_m = repeater_ref_clk_in_i;
      s_d.rep_s = s_q.rep_m;
      s_d.rep_p = s_q.rep_s;
      s_d.ext_m = ext_ref_clk_in_i;
      s_d.ext_s = s_q.ext_m;
      s_d.ext_p = s_q.ext_s;
      // A floating or grounded pin stops edges and the counter runs out
      if (s_q.rep_s && !s_q.rep_p) s_d.rep_cnt = LOSS8;
      else if (s_q.rep_cnt != 8'h00) s_d.rep_cnt = s_q.rep_cnt - 8'h01;
      if (s_q.ext_s && !s_q.ext_p) s_d.ext_cnt = LOSS8;
      else if (s_q.ext_cnt != 8'h00) s_d.ext_cnt = s_q.ext_cnt - 8'h01;
      s_d.use_rep = rif.ref_sel && (s_q.rep_cnt != 8'h00);
      if (s_q.use_rep) begin
         s_d.tx_clk = s_q.rep_s;
      end else if (s_q.ext_cnt != 8'h00) begin
         if (s_q.ext_s && !s_q.ext_p) s_d.tx_clk = !s_q.tx_clk;
      end else if (s_q.div == DIV_LAST) begin
         s_d.div = 2'h0;
         s_d.tx_clk = !s_q.tx_clk;
      end else begin
         s_d.div = s_q.div + 2'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) s_q <= '0;
      else s_q <= s_d;
   end

   assign rif.ext_active = (s_q.ext_cnt != 8'h00);
   assign rif.rep_active = (s_q.rep_cnt != 8'h00);
   assign rif.use_rep = s_q.use_rep;
   assign rif.tx_clk = s_q.tx_clk;

   property p_rep_follow;
      @(posedge clk_i) disable iff (!rstn_i)
      s_q.use_rep |=> s_q.tx_clk == $past(s_q.rep_s);
   endproperty
   a_rep_follow: assert property (p_rep_follow) else $error("tx clock lost repeater phase");

   property p_int_toggle;
      @(posedge clk_i) disable iff (!rstn_i)
      (!s_q.use_rep && s_q.ext_cnt == 8'h00 && s_q.div == DIV_LAST)
         |=> s_q.tx_clk != $past(s_q.tx_clk);
   endproperty
   a_int_toggle: assert property (p_int_toggle) else $error("internal tx clock stalled");

   c_use_rep: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(s_q.use_rep));
endmodule : ref_clk_select

//--- design/misc_strap_ctrl.sv
// Purpose: Strap capture, output disable, autonegotiation gating and APB config registers
// Assumes: 40 MHz clk_i, synchronous active-low reset, pins asynchronous to clk_i
// Notes: Strap pads are left undriven for a settle time after reset, then become LEDs
//
// Behaviour
// - Autoneg enabled only when pin AND register bit
// - Pulse on autoneg pin restarts negotiation
// - Output-disable pin floats every digital output (only the indicator pads and the transmit clock pin here)
// - Selected repeater reference drives the transmit clock
// - Internal synthesizer by default, external when present
// - Reference-select strap ORed with its register bit
// - Carrier-integrity strap ORed with its register bit
// - Codec-bypass strap ORed with its register bit
// - Scrambler-bypass strap merged only at reset
// - Strap pads then show per-port transmit activity
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module misc_strap_ctrl
   import misc_strap_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int LOSS_CYCLES = REF_LOSS_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Control pins
   input wire logic autoneg_en_pin_i,
   input wire logic output_hiz_in_i,
   input wire logic repeater_ref_clk_in_i,
   input wire logic ext_ref_clk_in_i,
   // Shared strap and indicator pads, port A in bit 0
   input wire logic [3:0] strap_pad_i,
   output logic [3:0] tx_activity_ind_o,
   output logic [3:0] tx_activity_ind_oe_o,
   // Transmit clock pin
   output logic tx_clk_o,
   output logic tx_clk_oe_o,
   // Port transmit activity
   input wire logic [3:0] tx_active_i,
   // Effective configuration
   output logic autoneg_enable_o,
   output logic autoneg_restart_o,
   output logic cim_enable_o,
   output logic codec_bypass_o,
   output logic scrambler_bypass_o,
   output logic repeater_ref_sel_o,
   output logic config_done_o
);
   localparam logic [15:0] CNT_LAST = 16'(SETTLE_CYCLES - 1);

   typedef enum logic [0:0] {ST_SETTLE, ST_RUN} phase_t;

   typedef struct packed {
      phase_t phase;
      logic [15:0] cnt;
      logic [3:0] pad_m;
      logic [3:0] pad_s;
      logic hiz_m;
      logic hiz_s;
      logic aneg_m;
      logic aneg_s;
      logic aneg_p;
      logic [3:0] strap;
      logic [31:0] reg0;
      logic [31:0] reg29;
      logic [31:0] reg30;
      logic [31:0] rdata;
      logic slverr;
      logic restart;
      cfg_t cfg;
      logic [3:0] ind;
      logic [3:0] ind_oe;
      logic clk_oe;
   } state_t;

   state_t s_q;
   state_t s_d;
   ref_ctrl_if rif ();

   initial begin
      if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) $error("SETTLE_CYCLES out of range");
   end

   function automatic logic reg_hit(input logic [11:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      return (addr[11:10] == 2'h0) &&
             (idx == ANEG_CTRL_IDX || idx == CFG29_IDX || idx == CFG30_IDX || idx == STAT_IDX);
   endfunction : reg_hit

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[i*8 +: 8] = wdata[i*8 +: 8] & mask[i*8 +: 8];
      end
      return res;
   endfunction : merge

   ref_clk_select #(
      .LOSS_CYCLES(LOSS_CYCLES)
   ) u_ref (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .repeater_ref_clk_in_i(repeater_ref_clk_in_i),
      .ext_ref_clk_in_i(ext_ref_clk_in_i),
      .rif(rif.leaf)
   );

   always_comb begin
      s_d = s_q;
      // Pin synchronisers
      s_d.pad_m = strap_pad_i;
      s_d.pad_s = s_q.pad_m;
      s_d.hiz_m = output_hiz_in_i;
      s_d.hiz_s = s_q.hiz_m;
      s_d.aneg_m = autoneg_en_pin_i;
      s_d.aneg_s = s_q.aneg_m;
      s_d.aneg_p = s_q.aneg_s;
      s_d.restart = 1'b0;

      // Register read is prepared in the setup phase so data comes from flops
      if (psel_i && !penable_i) begin
         s_d.slverr = !reg_hit(paddr_i);
         unique case (paddr_i[9:2])
            ANEG_CTRL_IDX: s_d.rdata = s_q.reg0;
            CFG29_IDX: s_d.rdata = s_q.reg29;
            CFG30_IDX: s_d.rdata = s_q.reg30;
            STAT_IDX: s_d.rdata = {20'h0_0000, s_q.strap, s_q.phase == ST_RUN, s_q.cfg.aneg,
                                   rif.use_rep, rif.ext_active, s_q.cfg.refsel,
                                   s_q.cfg.codec, s_q.cfg.scr, s_q.cfg.cim};
            default: s_d.rdata = 32'h0000_0000;
         endcase
         if (!reg_hit(paddr_i)) s_d.rdata = 32'h0000_0000;
      end
      if (psel_i && penable_i && pwrite_i && reg_hit(paddr_i)) begin
         unique case (paddr_i[9:2])
            ANEG_CTRL_IDX: s_d.reg0 = merge(s_q.reg0, pwdata_i, pstrb_i, ANEG_CTRL_MASK);
            CFG29_IDX: s_d.reg29 = merge(s_q.reg29, pwdata_i, pstrb_i, CFG29_MASK);
            CFG30_IDX: s_d.reg30 = merge(s_q.reg30, pwdata_i, pstrb_i, CFG30_MASK);
            default: s_d.reg30 = s_q.reg30;
         endcase
      end

      unique case (s_q.phase)
         ST_SETTLE: begin
            // Pads float while the strap resistors settle
            if (s_q.cnt == CNT_LAST) begin
               s_d.phase = ST_RUN;
               s_d.strap = s_q.pad_s;
               // Merged after the APB write so the strap wins a same-cycle clear
               s_d.reg29[SCR_BIT] = s_d.reg29[SCR_BIT] | s_q.pad_s[SCRAMBLER_BYPASS_STRAP];
            end else begin
               s_d.cnt = s_q.cnt + 16'h0001;
            end
         end
         ST_RUN: begin
            // Only a rising edge counts, so a held-high pin does not loop restarts
            if (s_q.aneg_s && !s_q.aneg_p && s_q.reg0[ANEG_EN_BIT]) s_d.restart = 1'b1;
         end
      endcase

      s_d.cfg.aneg = s_q.aneg_s & s_q.reg0[ANEG_EN_BIT];
      s_d.cfg.cim = s_q.strap[CARRIER_INTEGRITY_STRAP] | s_q.reg29[CIM_BIT];
      s_d.cfg.codec = s_q.strap[CODEC_BYPASS_STRAP] | s_q.reg29[CODEC_BIT];
      s_d.cfg.scr = s_q.reg29[SCR_BIT];
      s_d.cfg.refsel = s_q.strap[REF_SELECT_STRAP] | s_q.reg30[REFSEL_BIT];

      s_d.ind = (s_q.phase == ST_RUN) ? tx_active_i : 4'h0;
      s_d.ind_oe = {4{s_q.phase == ST_RUN && !s_q.hiz_s}};
      s_d.clk_oe = !s_q.hiz_s;
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
         s_q.reg0 <= ANEG_CTRL_RST;
         s_q.reg29 <= CFG29_RST;
         s_q.reg30 <= CFG30_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rif.ref_sel = s_q.cfg.refsel;
   assign pready_o = 1'b1;
   assign prdata_o = s_q.rdata;
   assign pslverr_o = s_q.slverr && psel_i && penable_i;
   assign tx_activity_ind_o = s_q.ind;
   assign tx_activity_ind_oe_o = s_q.ind_oe;
   assign tx_clk_o = rif.tx_clk;
   assign tx_clk_oe_o = s_q.clk_oe;
   assign autoneg_enable_o = s_q.cfg.aneg;
   assign autoneg_restart_o = s_q.restart;
   assign cim_enable_o = s_q.cfg.cim;
   assign codec_bypass_o = s_q.cfg.codec;
   assign scrambler_bypass_o = s_q.cfg.scr;
   assign repeater_ref_sel_o = s_q.cfg.refsel;
   assign config_done_o = (s_q.phase == ST_RUN);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   property p_aneg_and;
      ##1 autoneg_enable_o == $past(s_q.aneg_s && s_q.reg0[ANEG_EN_BIT]);
   endproperty
   a_aneg_and: assert property (p_aneg_and) else $error("autoneg enable not pin AND bit");

   property p_restart;
      (s_q.phase == ST_RUN && $rose(s_q.aneg_s) && s_q.reg0[ANEG_EN_BIT])
         |=> autoneg_restart_o ##1 !autoneg_restart_o;
   endproperty
   a_restart: assert property (p_restart) else $error("restart pulse missing");

   property p_hiz;
      s_q.hiz_s |=> (tx_activity_ind_oe_o == 4'h0) && !tx_clk_oe_o;
   endproperty
   a_hiz: assert property (p_hiz) else $error("output driven while disabled");

   property p_refsel;
      config_done_o ##1 config_done_o |->
         repeater_ref_sel_o == $past(s_q.strap[REF_SELECT_STRAP] | s_q.reg30[REFSEL_BIT]);
   endproperty
   a_refsel: assert property (p_refsel) else $error("reference select not ORed");

   property p_cim;
      config_done_o ##1 config_done_o |->
         cim_enable_o == $past(s_q.strap[CARRIER_INTEGRITY_STRAP] | s_q.reg29[CIM_BIT]);
   endproperty
   a_cim: assert property (p_cim) else $error("carrier integrity not ORed");

   property p_codec;
      config_done_o ##1 config_done_o |->
         codec_bypass_o == $past(s_q.strap[CODEC_BYPASS_STRAP] | s_q.reg29[CODEC_BIT]);
   endproperty
   a_codec: assert property (p_codec) else $error("codec bypass not ORed");

   property p_scr_load;
      (s_q.phase == ST_SETTLE && s_q.cnt == CNT_LAST && s_q.pad_s[SCRAMBLER_BYPASS_STRAP])
         |=> s_q.reg29[SCR_BIT] ##1 scrambler_bypass_o;
   endproperty
   a_scr_load: assert property (p_scr_load) else $error("scrambler strap not loaded");

   property p_ind;
      (config_done_o && !s_q.hiz_s) |=>
         tx_activity_ind_o == $past(tx_active_i) && tx_activity_ind_oe_o == 4'hf;
   endproperty
   a_ind: assert property (p_ind) else $error("indicator not following port");

   property p_hold;
      config_done_o |=> config_done_o && $stable(s_q.strap);
   endproperty
   a_hold: assert property (p_hold) else $error("strap value changed after capture");

   // Gating checks that the scenarios reach only indirectly
   property p_settle_oe;
      !config_done_o |=> tx_activity_ind_oe_o == 4'h0;
   endproperty
   a_settle_oe: assert property (p_settle_oe) else $error("pad driven early");

   property p_settle_ind;
      !config_done_o |=> tx_activity_ind_o == 4'h0;
   endproperty
   a_settle_ind: assert property (p_settle_ind) else $error("indicator active early");

   property p_capture;
      (s_q.phase == ST_SETTLE && s_q.cnt == CNT_LAST)
         |=> s_q.strap == $past(s_q.pad_s);
   endproperty
   a_capture: assert property (p_capture) else $error("strap not captured");

   property p_strap_zero;
      (!config_done_o && s_q.cnt != CNT_LAST)
         |=> s_q.strap == 4'h0;
   endproperty
   a_strap_zero: assert property (p_strap_zero) else $error("strap set early");

   property p_aneg_off;
      !s_q.reg0[ANEG_EN_BIT] |=> !autoneg_enable_o;
   endproperty
   a_aneg_off: assert property (p_aneg_off) else $error("autoneg on with bit clear");

   property p_aneg_pin_off;
      !s_q.aneg_s |=> !autoneg_enable_o;
   endproperty
   a_aneg_pin_off: assert property (p_aneg_pin_off) else $error("autoneg on with pin low");

   property p_restart_held;
      s_q.aneg_p |=> !autoneg_restart_o;
   endproperty
   a_restart_held: assert property (p_restart_held) else $error("restart on held pin");

   property p_restart_gate;
      !s_q.reg0[ANEG_EN_BIT] |=> !autoneg_restart_o;
   endproperty
   a_restart_gate: assert property (p_restart_gate) else $error("restart with bit clear");

   property p_restart_settle;
      !config_done_o |=> !autoneg_restart_o;
   endproperty
   a_restart_settle: assert property (p_restart_settle) else $error("early restart");

   property p_clk_oe_back;
      !s_q.hiz_s |=> tx_clk_oe_o;
   endproperty
   a_clk_oe_back: assert property (p_clk_oe_back) else $error("tx clock not driven");

   property p_scr_hold;
      (config_done_o && !s_q.reg29[SCR_BIT] && !(psel_i && penable_i && pwrite_i))
         |=> !s_q.reg29[SCR_BIT];
   endproperty
   a_scr_hold: assert property (p_scr_hold) else $error("scrambler bit set in run");

   property p_cim_strap;
      (config_done_o && s_q.strap[CARRIER_INTEGRITY_STRAP])
         |=> cim_enable_o;
   endproperty
   a_cim_strap: assert property (p_cim_strap) else $error("carrier strap ignored");

   property p_codec_strap;
      (config_done_o && s_q.strap[CODEC_BYPASS_STRAP])
         |=> codec_bypass_o;
   endproperty
   a_codec_strap: assert property (p_codec_strap) else $error("codec strap ignored");

   property p_refsel_strap;
      (config_done_o && s_q.strap[REF_SELECT_STRAP])
         |=> repeater_ref_sel_o;
   endproperty
   a_refsel_strap: assert property (p_refsel_strap) else $error("ref strap ignored");

   c_config_done: cover property ($rose(config_done_o));
   c_restart: cover property (autoneg_restart_o);
   c_hiz: cover property (config_done_o && $fell(tx_clk_oe_o));
   c_slverr: cover property (pslverr_o);
endmodule : misc_strap_ctrl

//--- test/misc_board_model.sv
// Purpose: Board side of the strap block: strap resistors, LED pads, reference sources
// Assumes: Sources step on clk_i edges, 10 MHz and 20 MHz taken from the 40 MHz clock
// Notes: A reference that is switched off sits grounded, as an unused pin would
`timescale 1ns/1ps
module misc_board_model (
   // Clock
   input wire logic clk_i,
   // Board setup
   input wire logic [3:0] strap_hi_i,
   input wire logic rep_on_i,
   input wire logic ext_on_i,
   // Shared pads
   input wire logic [3:0] led_i,
   input wire logic [3:0] led_oe_i,
   output logic [3:0] strap_pad_o,
   // Reference clocks
   output logic rep_clk_o,
   output logic ext_clk_o
);
   logic [1:0] div_q = 2'h0;

   // Resistor level shows only while the pad is released; the LED drive level otherwise
   assign strap_pad_o = (led_oe_i & led_i) | (~led_oe_i & strap_hi_i);
   always @(posedge clk_i) begin
      div_q <= div_q + 2'h1;
   end
   assign rep_clk_o = rep_on_i & div_q[1];
   assign ext_clk_o = ext_on_i & div_q[0];
endmodule : misc_board_model

//--- test/testbench.sv
// Purpose: Self-checking bench for the strap and miscellaneous control block
// Assumes: Short settle count; stimulus at rising edges, samples at falling edges
// Notes: Reference clocks come from the board model
`timescale 1ns/1ps
module testbench;
   import misc_strap_pkg::*;
   localparam int SETTLE = 4;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, rdv;
   logic pready_o, pslverr_o, errv, rep_clk, ext_clk, tx_clk_o, tx_clk_oe_o;
   logic autoneg_en_pin_i = 1'b0;
   logic output_hiz_in_i = 1'b0;
   logic [3:0] tx_active_i = 4'h0;
   logic [3:0] strap_hi = 4'h0;
   logic rep_on = 1'b0;
   logic ext_on = 1'b0;
   logic [3:0] pad, ind, ind_oe;
   logic an_en, an_rst, cim, codec, scr, refsel, done;
   int fails = 0;
   int n_compared = 0;

   always #12.5 clk_i = ~clk_i;

   misc_board_model board_u (.clk_i(clk_i), .strap_hi_i(strap_hi), .rep_on_i(rep_on),
      .ext_on_i(ext_on), .led_i(ind), .led_oe_i(ind_oe), .strap_pad_o(pad),
      .rep_clk_o(rep_clk), .ext_clk_o(ext_clk));

   misc_strap_ctrl #(.SETTLE_CYCLES(SETTLE), .LOSS_CYCLES(8)) dut_u (.clk_i(clk_i),
      .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .autoneg_en_pin_i(autoneg_en_pin_i),
      .output_hiz_in_i(output_hiz_in_i), .repeater_ref_clk_in_i(rep_clk),
      .ext_ref_clk_in_i(ext_clk), .strap_pad_i(pad), .tx_activity_ind_o(ind),
      .tx_activity_ind_oe_o(ind_oe), .tx_clk_o(tx_clk_o), .tx_clk_oe_o(tx_clk_oe_o),
      .tx_active_i(tx_active_i), .autoneg_enable_o(an_en), .autoneg_restart_o(an_rst),
      .cim_enable_o(cim), .codec_bypass_o(codec), .scrambler_bypass_o(scr),
      .repeater_ref_sel_o(refsel), .config_done_o(done));

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic hang(input string what);
      fails++;
      $display("[ERR] %s expected response seen none", what);
      print_verdict();
   endtask : hang

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= {2'b00, idx, 2'b00};
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) hang("pready");
      rdv = prdata_o;
      errv = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic settle(input int n);
      repeat (n) @(negedge clk_i);
   endtask : settle

   task automatic do_reset(input logic [3:0] s);
      int cyc;
      @(posedge clk_i);
      strap_hi <= s;
      rstn_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      chk("done in reset", 32'(done), 32'h0);
      chk("pads in reset", 32'(ind_oe), 32'h0);
      @(posedge clk_i);
      rstn_i <= 1'b1;
      cyc = 0;
      do begin
         @(negedge clk_i);
         cyc++;
      end while (done !== 1'b1 && cyc < 100);
      if (cyc >= 100) hang("config done");
      chk("settle cycles", 32'(cyc), 32'(SETTLE + 1));
   endtask : do_reset

   task automatic t_regs;
      do_reset(4'h0);
      apb(1'b0, ANEG_CTRL_IDX, 32'h0);
      chk("reg0 reset", rdv, ANEG_CTRL_RST);
      apb(1'b0, CFG29_IDX, 32'h0);
      chk("reg29 reset", rdv, CFG29_RST);
      apb(1'b0, CFG30_IDX, 32'h0);
      chk("reg30 reset", rdv, CFG30_RST);
      apb(1'b0, 8'h05, 32'h0);
      chk("unmapped err", 32'(errv), 32'h1);
      chk("unmapped data", rdv, 32'h0);
      settle(2);
      chk("no strap cfg", {cim, codec, scr, refsel}, 4'h0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_straps;
      do_reset(4'hf);
      // Merged outputs follow the captured straps one cycle later
      settle(2);
      chk("strap cfg", {cim, codec, scr, refsel}, 4'hf);
      apb(1'b0, STAT_IDX, 32'h0);
      chk("captured straps", rdv[11:8], 4'hf);
      apb(1'b1, CFG29_IDX, 32'h0);
      apb(1'b1, CFG30_IDX, 32'h0);
      settle(3);
      chk("scr strap only at reset", 32'(scr), 32'h0);
      chk("cim/codec/ref held", {cim, codec, refsel}, 3'h7);
      chk("codec held", 32'(codec), 32'h1);
      $display("test straps done");
   endtask : t_straps

   task automatic t_or;
      do_reset(4'h0);
      apb(1'b1, CFG29_IDX, 32'h58);
      apb(1'b1, CFG30_IDX, 32'h4);
      settle(2);
      chk("reg ored in", {cim, codec, scr, refsel}, 4'hf);
      apb(1'b1, CFG29_IDX, 32'h0);
      apb(1'b1, CFG30_IDX, 32'h0);
      settle(2);
      chk("reg cleared", {cim, codec, scr, refsel}, 4'h0);
      $display("test or done");
   endtask : t_or

   task automatic t_leds;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         tx_active_i <= 4'(1 << i);
         settle(2);
         chk("port led", 32'(ind), 32'(1 << i));
         chk("led enable", 32'(ind_oe), 32'hf);
         chk("cfg kept", 32'(done), 32'h1);
      end
      @(posedge clk_i);
      output_hiz_in_i <= 1'b1;
      settle(4);
      chk("hiz leds", 32'(ind_oe), 32'h0);
      chk("hiz txclk", 32'(tx_clk_oe_o), 32'h0);
      @(posedge clk_i);
      output_hiz_in_i <= 1'b0;
      settle(4);
      chk("leds back", {ind_oe, tx_clk_oe_o}, 5'h1f);
      $display("test leds done");
   endtask : t_leds

   task automatic aneg_pulse(input logic [31:0] exp_en, input logic [31:0] exp_n);
      int n;
      n = 0;
      @(posedge clk_i);
      autoneg_en_pin_i <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         @(negedge clk_i);
         n += 32'(an_rst);
      end
      chk("aneg enable", 32'(an_en), exp_en);
      chk("restart pulses", 32'(n), exp_n);
      @(posedge clk_i);
      autoneg_en_pin_i <= 1'b0;
      settle(5);
      chk("aneg pin low", 32'(an_en), 32'h0);
   endtask : aneg_pulse

   task automatic t_aneg;
      aneg_pulse(32'h1, 32'h1);
      apb(1'b1, ANEG_CTRL_IDX, 32'h0);
      aneg_pulse(32'h0, 32'h0);
      apb(1'b1, ANEG_CTRL_IDX, ANEG_CTRL_RST);
      aneg_pulse(32'h1, 32'h1);
      $display("test aneg done");
   endtask : t_aneg

   task automatic t_clk;
      logic [39:0] tv, rv;
      int t, ok;
      t = 0;
      for (int j = 0; j < 33; j++) begin
         @(negedge clk_i);
         tv[j % 2] = tx_clk_o;
         if (j > 0 && tv[0] !== tv[1]) t++;
      end
      chk("internal tx clk", 32'(t), 32'd16);
      @(posedge clk_i);
      ext_on <= 1'b1;
      settle(20);
      apb(1'b0, STAT_IDX, 32'h0);
      chk("ext clk active", 32'(rdv[5:4]), 32'h1);
      @(posedge clk_i);
      rep_on <= 1'b1;
      apb(1'b1, CFG30_IDX, 32'h4);
      settle(20);
      for (int j = 0; j < 40; j++) begin
         @(negedge clk_i);
         tv[j] = tx_clk_o;
         rv[j] = rep_clk;
      end
      ok = 0;
      for (int k = 1; k < 8; k++) begin
         if (tv[39:8] === rv[39 - k -: 32]) ok = 1;
      end
      chk("tx clk follows ref", 32'(ok), 32'h1);
      apb(1'b0, STAT_IDX, 32'h0);
      chk("repeater in use", 32'(rdv[5]), 32'h1);
      @(posedge clk_i);
      rep_on <= 1'b0;
      settle(20);
      apb(1'b0, STAT_IDX, 32'h0);
      chk("repeater lost", 32'(rdv[5]), 32'h0);
      $display("test clk done");
   endtask : t_clk

   initial begin
      t_regs();
      t_straps();
      t_or();
      t_leds();
      t_aneg();
      t_clk();
      print_verdict();
   end
endmodule : testbench
